// ### pmu_regulator_config_regs.sv
/*
 * Regulator configuration registers: buck2 ramp limiter, spread-spectrum
 * sweep, power-good delay, undervoltage shutdown and linear regulator set
 * points. Requests come as single-cycle strobes from the serial slave
 * engine; straps are stable at reset release.
 */
// Notes on behaviour
// - Ramp code in D3-D0: 0 is instant, 1..A give 1..10 mV/us, B..F act as 10 mV/us.
// - The ramp rate applies only while buck2 moves between two target voltages.
// - Spread spectrum sweeps the switch clock up and down around a 2 MHz centre.
// - Function bit D0 enables spread spectrum, reset 0.
// - Function bit D1 picks a 10 kHz (0) or 2 kHz (1) triangle sweep, reset 1.
// - Function bits D3-D2 pick 50 us, 50 ms, 100 ms or 200 ms power-good delay, reset 01.
// - The power-good reset output follows both buck outputs using the chosen delay.
// - A raw supply below 2.8 V turns all four regulators off.
// - Function bit D4 bypasses the undervoltage shutdown; its reset value is a strap.
// - Linear reg 1 code: 1.0 V at 0, plus 0.1 V per code, 3.5 V at 19h and above.
// - Linear reg 2 uses the same mapping and resets to a strapped code.
// - With the fixed option strapped both linear regs give 2.85 V whatever the code.
// - All registers are read and written over the serial port; rails are switched on by i_rail_on_req.
`timescale 1ns/1ns
`default_nettype none
module pmu_regulator_config_regs #(
   parameter int unsigned PG_CYC_0 = pmu_cfg_pkg::PG_CYC0,
   parameter int unsigned PG_CYC_1 = pmu_cfg_pkg::PG_CYC1,
   parameter int unsigned PG_CYC_2 = pmu_cfg_pkg::PG_CYC2,
   parameter int unsigned PG_CYC_3 = pmu_cfg_pkg::PG_CYC3
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst_n,
   input  wire pmu_cfg_pkg::reg_req_t       i_req,
   output logic [7:0]                       o_rdata,
   input  wire pmu_cfg_pkg::factory_strap_t i_strap,
   input  wire logic [11:0]                 i_buck2_target_mv,
   output logic [11:0]                      o_buck2_level_mv,
   output logic [3:0]                       o_buck2_rate_mv_us,
   output logic                             o_spread_active,
   output logic [7:0]                       o_spread_offset,
   input  wire logic                        i_buck1_ok,
   input  wire logic                        i_buck2_ok,
   output logic                             o_power_good_reset_n,
   input  wire logic                        i_raw_supply_low,
   input  wire logic [3:0]                  i_rail_on_req,
   output logic [3:0]                       o_rail_enable,
   output pmu_cfg_pkg::ldo_setpoint_t       o_ldo_setpoint
);
   import pmu_cfg_pkg::*;

   typedef enum logic [2:0] {
      PG_LOW  = 3'b001,
      PG_WAIT = 3'b010,
      PG_OK   = 3'b100
   } pg_state_t;

   function automatic logic [8:0] ldo_10mv(input logic [4:0] code, input logic fixed);
      logic [4:0] c;
      c = (code > LDO_CODE_MAX) ? LDO_CODE_MAX : code;
      ldo_10mv = fixed ? LDO_FIXED_10MV
                       : 9'(LDO_BASE_10MV + 9'(c) * LDO_STEP_10MV);
   endfunction : ldo_10mv

   function automatic logic [3:0] ramp_rate(input logic [3:0] code);
      ramp_rate = (code > RAMP_CODE_MAX) ? RAMP_CODE_MAX : code;
   endfunction : ramp_rate

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic       loaded_ff, nxt_loaded;
   logic [3:0] ramp_code_ff, nxt_ramp_code;
   logic       spread_on_ff, nxt_spread_on;
   logic       spread_mod_ff, nxt_spread_mod;
   logic [1:0] pg_delay_ff, nxt_pg_delay;
   logic       uv_bypass_ff, nxt_uv_bypass;
   logic [4:0] ldo1_code_ff, nxt_ldo1_code;
   logic [4:0] ldo2_code_ff, nxt_ldo2_code;
   logic       fixed_opt_ff, nxt_fixed_opt;
   logic [7:0] rdata_ff, nxt_rdata;

   always_comb begin
      nxt_loaded     = 1'b1;
      nxt_ramp_code  = ramp_code_ff;
      nxt_spread_on  = spread_on_ff;
      nxt_spread_mod = spread_mod_ff;
      nxt_pg_delay   = pg_delay_ff;
      nxt_uv_bypass  = uv_bypass_ff;
      nxt_ldo1_code  = ldo1_code_ff;
      nxt_ldo2_code  = ldo2_code_ff;
      nxt_fixed_opt  = fixed_opt_ff;
      nxt_rdata      = rdata_ff;
      if (!loaded_ff) begin
         // Straps caught once, after reset release
         nxt_uv_bypass = i_strap.uv_bypass;
         nxt_ldo1_code = i_strap.ldo1_code;
         nxt_ldo2_code = i_strap.ldo2_code;
         nxt_fixed_opt = i_strap.fixed_ldo_option;
      end else if (i_req.wr_en) begin
         unique case (i_req.addr)
            ADDR_BUCK2_RAMP_RATE: nxt_ramp_code = i_req.wdata[3:0];
            ADDR_BUCK_FUNCTION_CTRL: begin
               nxt_spread_on  = i_req.wdata[SPREAD_ON_BIT];
               nxt_spread_mod = i_req.wdata[SPREAD_MOD_BIT];
               nxt_pg_delay   = i_req.wdata[PG_DELAY_LSB +: 2];
               nxt_uv_bypass  = i_req.wdata[UV_BYPASS_BIT];
            end
            ADDR_LINEAR_REG1_VOLTAGE: nxt_ldo1_code = i_req.wdata[4:0];
            ADDR_LINEAR_REG2_VOLTAGE: nxt_ldo2_code = i_req.wdata[4:0];
            default: ;
         endcase
      end
      if (i_req.rd_en) begin
         nxt_rdata = 8'h00;
         unique case (i_req.addr)
            ADDR_BUCK2_RAMP_RATE:     nxt_rdata[3:0] = ramp_code_ff;
            ADDR_BUCK_FUNCTION_CTRL: begin
               nxt_rdata[SPREAD_ON_BIT]      = spread_on_ff;
               nxt_rdata[SPREAD_MOD_BIT]     = spread_mod_ff;
               nxt_rdata[PG_DELAY_LSB +: 2]  = pg_delay_ff;
               nxt_rdata[UV_BYPASS_BIT]      = uv_bypass_ff;
            end
            ADDR_LINEAR_REG1_VOLTAGE: nxt_rdata[4:0] = ldo1_code_ff;
            ADDR_LINEAR_REG2_VOLTAGE: nxt_rdata[4:0] = ldo2_code_ff;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         loaded_ff     <= 1'b0;
         ramp_code_ff  <= RAMP_CODE_RST;
         spread_on_ff  <= SPREAD_ON_RST;
         spread_mod_ff <= SPREAD_MOD_RST;
         pg_delay_ff   <= PG_DELAY_RST;
         uv_bypass_ff  <= 1'b0;
         ldo1_code_ff  <= 5'h00;
         ldo2_code_ff  <= 5'h00;
         fixed_opt_ff  <= 1'b0;
         rdata_ff      <= 8'h00;
      end else begin
         loaded_ff     <= nxt_loaded;
         ramp_code_ff  <= nxt_ramp_code;
         spread_on_ff  <= nxt_spread_on;
         spread_mod_ff <= nxt_spread_mod;
         pg_delay_ff   <= nxt_pg_delay;
         uv_bypass_ff  <= nxt_uv_bypass;
         ldo1_code_ff  <= nxt_ldo1_code;
         ldo2_code_ff  <= nxt_ldo2_code;
         fixed_opt_ff  <= nxt_fixed_opt;
         rdata_ff      <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Buck2 ramp limiter: 1 mV per (1000 / rate) ns
   // ----------------------------------------------------------------
   logic [11:0] level_ff, nxt_level;
   logic [6:0]  ramp_cnt_ff, nxt_ramp_cnt;
   logic [6:0]  ramp_period;

   always_comb begin
      ramp_period  = (ramp_rate(ramp_code_ff) == 4'h0) ? 7'h01
                   : 7'(NS_PER_US / CLK_NS / int'(ramp_rate(ramp_code_ff)));
      nxt_level    = level_ff;
      nxt_ramp_cnt = 7'h00;
      if (!loaded_ff || ramp_code_ff == 4'h0) begin
         nxt_level = i_buck2_target_mv;
      end else if (level_ff != i_buck2_target_mv) begin
         if (ramp_cnt_ff >= 7'(ramp_period - 7'h01)) begin
            nxt_level = (level_ff < i_buck2_target_mv) ? 12'(level_ff + 12'h001)
                                                       : 12'(level_ff - 12'h001);
         end else begin
            nxt_ramp_cnt = 7'(ramp_cnt_ff + 7'h01);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         level_ff    <= 12'h000;
         ramp_cnt_ff <= 7'h00;
      end else begin
         level_ff    <= nxt_level;
         ramp_cnt_ff <= nxt_ramp_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Spread-spectrum triangle (offset around the centre frequency)
   // ----------------------------------------------------------------
   logic [7:0] tri_ff, nxt_tri;
   logic       up_ff, nxt_up;
   logic [6:0] ss_cnt_ff, nxt_ss_cnt;
   logic [6:0] ss_div;

   always_comb begin
      ss_div     = spread_mod_ff ? 7'(SS_SLOW_DIV) : 7'(SS_FAST_DIV);
      nxt_tri    = tri_ff;
      nxt_up     = up_ff;
      nxt_ss_cnt = 7'(ss_cnt_ff + 7'h01);
      if (!spread_on_ff) begin
         nxt_tri    = SS_MID;
         nxt_up     = 1'b1;
         nxt_ss_cnt = 7'h00;
      end else if (ss_cnt_ff >= 7'(ss_div - 7'h01)) begin
         nxt_ss_cnt = 7'h00;
         nxt_tri    = up_ff ? 8'(tri_ff + 8'h01) : 8'(tri_ff - 8'h01);
         if (up_ff && tri_ff == 8'(SS_TOP - 8'h01)) nxt_up = 1'b0;
         if (!up_ff && tri_ff == 8'(SS_BOTTOM + 8'h01)) nxt_up = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tri_ff    <= SS_MID;
         up_ff     <= 1'b1;
         ss_cnt_ff <= 7'h00;
      end else begin
         tri_ff    <= nxt_tri;
         up_ff     <= nxt_up;
         ss_cnt_ff <= nxt_ss_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Power-good delay
   // ----------------------------------------------------------------
   pg_state_t   pg_ff, nxt_pg;
   logic [24:0] pg_cnt_ff, nxt_pg_cnt;
   logic [24:0] pg_target;
   logic        bucks_ok;

   always_comb begin
      bucks_ok = i_buck1_ok & i_buck2_ok;
      unique case (pg_delay_ff)
         2'h0: pg_target = 25'(PG_CYC_0);
         2'h1: pg_target = 25'(PG_CYC_1);
         2'h2: pg_target = 25'(PG_CYC_2);
         2'h3: pg_target = 25'(PG_CYC_3);
      endcase
      nxt_pg     = pg_ff;
      nxt_pg_cnt = 25'h0;
      unique case (pg_ff)
         PG_LOW:  if (bucks_ok) nxt_pg = PG_WAIT;
         PG_WAIT: begin
            nxt_pg_cnt = 25'(pg_cnt_ff + 25'h1);
            if (!bucks_ok) nxt_pg = PG_LOW;
            else if (pg_cnt_ff >= 25'(pg_target - 25'h1)) nxt_pg = PG_OK;
         end
         PG_OK:   if (!bucks_ok) nxt_pg = PG_LOW;
         default: nxt_pg = PG_LOW;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pg_ff     <= PG_LOW;
         pg_cnt_ff <= 25'h0;
      end else begin
         pg_ff     <= nxt_pg;
         pg_cnt_ff <= nxt_pg_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Shutdown is combinational so a supply dip removes rails at once
   assign o_rail_enable        = i_rail_on_req & {4{~i_raw_supply_low | uv_bypass_ff}};
   assign o_rdata              = rdata_ff;
   assign o_buck2_level_mv     = level_ff;
   assign o_buck2_rate_mv_us   = ramp_rate(ramp_code_ff);
   assign o_spread_active      = spread_on_ff;
   assign o_spread_offset      = tri_ff;
   assign o_power_good_reset_n = (pg_ff == PG_OK);
   // One assignment for the whole carrier, so the port has a single driver
   assign o_ldo_setpoint = '{ldo1_10mv: ldo_10mv(ldo1_code_ff, fixed_opt_ff),
                             ldo2_10mv: ldo_10mv(ldo2_code_ff, fixed_opt_ff)};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   uv_shutdown_a: assert property (i_raw_supply_low && !uv_bypass_ff |-> o_rail_enable == 4'h0)
      else $error("rails on during undervoltage");
   uv_bypass_a: assert property (uv_bypass_ff |-> o_rail_enable == i_rail_on_req)
      else $error("bypass ignored");
   pg_release_a: assert property ($rose(o_power_good_reset_n) |-> $past(bucks_ok, 1))
      else $error("power good without bucks ok");
   pg_drop_a: assert property (!bucks_ok |=> !o_power_good_reset_n)
      else $error("power good held after fault");
   pg_delay_a: assert property (pg_ff == PG_WAIT && pg_delay_ff == 2'h0 && bucks_ok
                                |-> pg_cnt_ff <= 25'(PG_CYC_0))
      else $error("short delay overrun");
   ramp_still_a: assert property (loaded_ff && ramp_code_ff != 4'h0
                                  && level_ff == i_buck2_target_mv && $stable(i_buck2_target_mv)
                                  |=> $stable(level_ff))
      else $error("level moved at target");
   ramp_instant_a: assert property (loaded_ff && ramp_code_ff == 4'h0
                                    |=> level_ff == $past(i_buck2_target_mv))
      else $error("instant ramp lagged");
   ramp_clamp_a: assert property (o_buck2_rate_mv_us <= RAMP_CODE_MAX)
      else $error("ramp rate above limit");
   spread_idle_a: assert property (!spread_on_ff |=> tri_ff == SS_MID)
      else $error("sweep while disabled");
   spread_step_a: assert property (spread_on_ff && $past(spread_on_ff) && tri_ff != $past(tri_ff)
                                   |-> (tri_ff == 8'($past(tri_ff) + 8'h01))
                                       || (tri_ff == 8'($past(tri_ff) - 8'h01)))
      else $error("sweep jumped");
   ldo_fixed_a: assert property (fixed_opt_ff |-> o_ldo_setpoint.ldo1_10mv == LDO_FIXED_10MV
                                 && o_ldo_setpoint.ldo2_10mv == LDO_FIXED_10MV)
      else $error("fixed option ignored");
   ldo_map_a: assert property (!fixed_opt_ff && ldo1_code_ff > LDO_CODE_MAX
                               |-> o_ldo_setpoint.ldo1_10mv == 9'h15e)
      else $error("ldo1 clamp wrong");
   rsvd_read_a: assert property (i_req.rd_en && i_req.addr == ADDR_LINEAR_REG2_VOLTAGE
                                 |=> o_rdata[7:5] == 3'h0)
      else $error("reserved bits nonzero");

   pg_full_c:    cover property (pg_ff == PG_WAIT ##1 pg_ff == PG_OK);
   ramp_move_c:  cover property (level_ff != i_buck2_target_mv ##1 $changed(level_ff));
   spread_turn_c: cover property (spread_on_ff && $fell(up_ff));
   uv_trip_c:    cover property (i_raw_supply_low && !uv_bypass_ff && i_rail_on_req != 4'h0);

endmodule : pmu_regulator_config_regs
`default_nettype wire

// ### pmu_cfg_pkg.sv
/*
 * Constants, register map and carrier types for the regulator
 * configuration register bank.
 * Assumes a 100 MHz core clock and an external serial slave engine that
 * turns bus transfers into single-cycle byte reads and writes.
 */
`default_nettype none
package pmu_cfg_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_BUCK2_RAMP_RATE     = 8'h2b;
   localparam logic [7:0] ADDR_BUCK_FUNCTION_CTRL  = 8'h38;
   localparam logic [7:0] ADDR_LINEAR_REG1_VOLTAGE = 8'h39;
   localparam logic [7:0] ADDR_LINEAR_REG2_VOLTAGE = 8'h3a;
   // Field positions in buck_function_ctrl
   localparam int unsigned SPREAD_ON_BIT   = 0;
   localparam int unsigned SPREAD_MOD_BIT  = 1;
   localparam int unsigned PG_DELAY_LSB    = 2;
   localparam int unsigned UV_BYPASS_BIT   = 4;
   // Reset values of the fixed fields
   localparam logic [3:0] RAMP_CODE_RST    = 4'h8;
   localparam logic [1:0] PG_DELAY_RST     = 2'h1;
   localparam logic       SPREAD_MOD_RST   = 1'b1;
   localparam logic       SPREAD_ON_RST    = 1'b0;
   // -------------------------------------------------------------
   // Code limits and voltage scaling (10 mV units)
   // -------------------------------------------------------------
   localparam logic [3:0] RAMP_CODE_MAX    = 4'ha;
   localparam logic [4:0] LDO_CODE_MAX     = 5'h19;
   localparam logic [8:0] LDO_BASE_10MV    = 9'h064;
   localparam logic [8:0] LDO_STEP_10MV    = 9'h00a;
   localparam logic [8:0] LDO_FIXED_10MV   = 9'h11d;
   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_NS        = 10;
   localparam int unsigned NS_PER_US     = 1000;
   localparam int unsigned NS_PER_MS     = 1000000;
   localparam int unsigned SS_CENTRE_KHZ = 2000;
   localparam int unsigned SS_FAST_HZ    = 10000;
   localparam int unsigned SS_SLOW_HZ    = 2000;
   localparam int unsigned SS_STEPS      = 510;
   localparam logic [7:0]  SS_MID        = 8'h80;
   localparam logic [7:0]  SS_TOP        = 8'hff;
   localparam logic [7:0]  SS_BOTTOM     = 8'h00;
   localparam int unsigned SS_FAST_DIV   = (1000000000 / SS_FAST_HZ) / CLK_NS / SS_STEPS;
   localparam int unsigned SS_SLOW_DIV   = (1000000000 / SS_SLOW_HZ) / CLK_NS / SS_STEPS;
   localparam int unsigned PG_T0_US      = 50;
   localparam int unsigned PG_T1_MS      = 50;
   localparam int unsigned PG_T2_MS      = 100;
   localparam int unsigned PG_T3_MS      = 200;
   localparam int unsigned PG_CYC0       = PG_T0_US * NS_PER_US / CLK_NS;
   localparam int unsigned PG_CYC1       = PG_T1_MS * NS_PER_MS / CLK_NS;
   localparam int unsigned PG_CYC2       = PG_T2_MS * NS_PER_MS / CLK_NS;
   localparam int unsigned PG_CYC3       = PG_T3_MS * NS_PER_MS / CLK_NS;
   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic       uv_bypass;
      logic [4:0] ldo1_code;
      logic [4:0] ldo2_code;
      logic       fixed_ldo_option;
   } factory_strap_t;
   typedef struct packed {
      logic [8:0] ldo1_10mv;
      logic [8:0] ldo2_10mv;
   } ldo_setpoint_t;
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
endpackage : pmu_cfg_pkg
`default_nettype wire

// ### pmu_host_model.sv
/*
 * Host side of the register port: issues single-byte writes and reads.
 * Assumes the bank takes a strobe on the next rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module pmu_host_model (
   input  wire logic                 i_clk,
   input  wire logic [7:0]           i_rdata,
   output var pmu_cfg_pkg::reg_req_t o_req
);
   import pmu_cfg_pkg::*;
   initial o_req = '0;
   // Released bus shows inverted values, never the last ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_req <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk);
      o_req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk);
      o_req <= '{1'b0, 1'b0, ~a, 8'hff};
      #1 d = i_rdata;
   endtask : rd
endmodule : pmu_host_model
`default_nettype wire

// ### pmu_regulator_config_regs_tb_top.sv
/*
 * Self-checking bench for the regulator configuration bank.
 * Assumes the host model drives the register port; short delay counts.
 */
`timescale 1ns/1ns
`default_nettype none
module pmu_regulator_config_regs_tb_top;
   import pmu_cfg_pkg::*;
   logic           i_clk = 0, i_rst_n = 0, b1 = 0, b2 = 0, low = 0;
   logic [11:0]    tgt = 12'd1000, lvl;
   logic [3:0]     rate, rq = 4'hf, ren;
   logic [7:0]     rdata, off, d;
   logic           act, pg;
   reg_req_t       req;
   ldo_setpoint_t  sp;
   factory_strap_t strap = '{1'b0, 5'h03, 5'h07, 1'b0};
   int             n_errors = 0, checks = 0, cyc = 0;
   always #5 i_clk = ~i_clk;
   pmu_host_model u_pmu_host_model (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));
   pmu_regulator_config_regs #(.PG_CYC_0(5), .PG_CYC_1(10), .PG_CYC_2(20), .PG_CYC_3(40))
   u_pmu_regulator_config_regs (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(rdata), .i_strap(strap),
      .i_buck2_target_mv(tgt), .o_buck2_level_mv(lvl), .o_buck2_rate_mv_us(rate),
      .o_spread_active(act), .o_spread_offset(off), .i_buck1_ok(b1), .i_buck2_ok(b2),
      .o_power_good_reset_n(pg), .i_raw_supply_low(low), .i_rail_on_req(rq),
      .o_rail_enable(ren), .o_ldo_setpoint(sp));
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   task automatic t_reset_values();
      u_pmu_host_model.rd(ADDR_BUCK2_RAMP_RATE, d); chk(d, 12'h08);
      u_pmu_host_model.rd(ADDR_BUCK_FUNCTION_CTRL, d); chk(d, 12'h06);
      u_pmu_host_model.rd(ADDR_LINEAR_REG1_VOLTAGE, d); chk(d, 12'h03);
      u_pmu_host_model.rd(ADDR_LINEAR_REG2_VOLTAGE, d); chk(d, 12'h07);
      u_pmu_host_model.rd(8'h3b, d); chk(d, 12'h00);
      chk(sp.ldo2_10mv, 12'd170);
      $display("test reset_values done");
   endtask : t_reset_values
   task automatic t_ldo_codes();
      u_pmu_host_model.wr(ADDR_LINEAR_REG1_VOLTAGE, 8'hff);
      u_pmu_host_model.rd(ADDR_LINEAR_REG1_VOLTAGE, d); chk(d, 12'h1f);
      chk(sp.ldo1_10mv, 12'd350);
      u_pmu_host_model.wr(ADDR_LINEAR_REG1_VOLTAGE, 8'h19);
      tick(1); chk(sp.ldo1_10mv, 12'd350);
      u_pmu_host_model.wr(ADDR_LINEAR_REG2_VOLTAGE, 8'h00);
      tick(1); chk(sp.ldo2_10mv, 12'd100);
      u_pmu_host_model.wr(8'h3b, 8'h55);
      u_pmu_host_model.rd(ADDR_LINEAR_REG2_VOLTAGE, d); chk(d, 12'h00);
      $display("test ldo_codes done");
   endtask : t_ldo_codes
   task automatic t_ramp();
      u_pmu_host_model.wr(ADDR_BUCK2_RAMP_RATE, 8'hf0);
      tick(1); chk(rate, 12'h0);
      @(posedge i_clk) tgt <= 12'd1040;
      tick(2); chk(lvl, 12'd1040);
      u_pmu_host_model.wr(ADDR_BUCK2_RAMP_RATE, 8'h0f);
      u_pmu_host_model.rd(ADDR_BUCK2_RAMP_RATE, d); chk(d, 12'h0f);
      chk(rate, 12'd10);
      @(posedge i_clk) tgt <= 12'd1045;
      tick(25); chk(12'(lvl > 12'd1040 && lvl < 12'd1045), 12'h1);
      tick(60); chk(lvl, 12'd1045);
      tick(30); chk(lvl, 12'd1045);
      $display("test ramp done");
   endtask : t_ramp
   task automatic t_power_good();
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'h0c);
      @(posedge i_clk) {b1, b2} <= 2'b11;
      tick(30); chk(pg, 12'h0);
      tick(20); chk(pg, 12'h1);
      @(posedge i_clk) b1 <= 1'b0;
      tick(1); chk(pg, 12'h0);
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'h00);
      @(posedge i_clk) b1 <= 1'b1;
      tick(3); chk(pg, 12'h0);
      tick(6); chk(pg, 12'h1);
      @(posedge i_clk) b2 <= 1'b0;
      tick(1); chk(pg, 12'h0);
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'h08);
      @(posedge i_clk) b2 <= 1'b1;
      tick(18); chk(pg, 12'h0);
      tick(5); chk(pg, 12'h1);
      @(posedge i_clk) b1 <= 1'b0;
      tick(1); chk(pg, 12'h0);
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'h04);
      @(posedge i_clk) b1 <= 1'b1;
      tick(8); chk(pg, 12'h0);
      tick(5); chk(pg, 12'h1);
      @(posedge i_clk) {b1, b2} <= 2'b00;
      tick(1); chk(pg, 12'h0);
      $display("test power_good done");
   endtask : t_power_good
   task automatic t_spread();
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'h01);
      tick(1); chk(act, 12'h1);
      tick(70); chk(12'(off > 8'h80 && off < 8'h88), 12'h1);
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'h00);
      tick(2); chk(act, 12'h0);
      chk(off, 12'h80);
      // Slow sweep: a fast divider would already have stepped three times
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'h03);
      tick(59); chk(off, 12'h80);
      tick(45); chk(off, 12'h81);
      $display("test spread done");
   endtask : t_spread
   task automatic t_undervoltage();
      @(posedge i_clk) low <= 1'b1;
      tick(1); chk(ren, 12'h0);
      u_pmu_host_model.wr(ADDR_BUCK_FUNCTION_CTRL, 8'hf0);
      tick(1); chk(ren, 12'hf);
      u_pmu_host_model.rd(ADDR_BUCK_FUNCTION_CTRL, d); chk(d, 12'h10);
      @(posedge i_clk) rq <= 4'h5;
      tick(1); chk(ren, 12'h5);
      $display("test undervoltage done");
   endtask : t_undervoltage
   // Straps are caught only after a reset, so this one resets mid-run
   task automatic t_fixed_option();
      @(posedge i_clk) i_rst_n <= 1'b0;
      strap <= '{1'b1, 5'h0a, 5'h1c, 1'b1};
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      tick(2); chk(sp.ldo1_10mv, 12'd285);
      chk(sp.ldo2_10mv, 12'd285);
      chk(ren, 12'h5);
      chk(lvl, 12'd1045);
      u_pmu_host_model.rd(ADDR_BUCK_FUNCTION_CTRL, d); chk(d, 12'h16);
      u_pmu_host_model.rd(ADDR_LINEAR_REG2_VOLTAGE, d); chk(d, 12'h1c);
      $display("test fixed_option done");
   endtask : t_fixed_option
   task automatic finish_test();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   // Whole run needs well under a thousand cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      t_reset_values();
      t_ldo_codes();
      t_ramp();
      t_power_good();
      t_spread();
      t_undervoltage();
      t_fixed_option();
      finish_test();
   end
endmodule : pmu_regulator_config_regs_tb_top
`default_nettype wire
